// File: src/vtr_unit.sv
// vector selection, interrupt acknowledge and table read unit
`timescale 1ns/100ps
module vtr_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources and enables
  input wire logic ext_int_pin,
  input wire logic timer_ovf,
  input wire logic tbase_evt,
  input wire logic adc_done,
  input wire logic [3:0] src_enable,
  input wire logic global_enable,
  // stack and sequencer handshake
  input wire logic stack_full,
  input wire logic [10:0] core_pc,
  input wire logic core_ready,
  output logic branch_valid,
  output logic [10:0] branch_addr,
  output logic push_valid,
  output logic [10:0] push_pc,
  output logic [3:0] pending,
  // table read request and program memory
  input wire vtr_pkg::vtr_tbl_req_s tbl_req,
  output logic tbl_busy,
  output logic pmem_rd,
  output logic [10:0] pmem_addr,
  input wire logic [13:0] pmem_data,
  output vtr_pkg::vtr_tbl_wr_s tbl_wr,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////
  logic ext_edge;
  logic [3:0] flags;
  logic [3:0] raw;
  logic [3:0] ready_src;
  logic [3:0] grant;
  logic [7:0] tbl_low;
  logic [7:0] tbl_high;
  logic [10:0] last_tbl_addr;
  logic [10:0] pc_shadow;
  logic [vtr_pkg::EV_W-1:0] stat;
  logic [vtr_pkg::EV_W-1:0] int_en;
  logic reset_vec_done;
  logic held_evt;
  logic tbl_evt;
  vtr_pkg::vtr_state_e state;
  vtr_pkg::vtr_state_e next_state;
  vtr_pkg::vtr_tbl_req_s req_hold;
  logic apb_wr;
  logic apb_rd;
  logic branch_go;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  vtr_edge_sync u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_int_pin),
    .edge_seen(ext_edge)
  );

  ////////////////////////////////////////////////////////////////
  // request flags stay set until acknowledged, so a full stack only delays
  assign raw = {adc_done, tbase_evt, timer_ovf, ext_edge};
  assign ready_src = flags & src_enable & {4{global_enable}};
  // lowest vector first
  assign grant = ready_src & (~ready_src + 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 4'h0;
    end else begin
      // a new event in the acknowledge cycle survives: set wins
      flags <= (flags & ~(branch_go ? grant : 4'h0)) | raw;
    end
  end

  assign branch_go = reset_vec_done && core_ready && !stack_full && (ready_src != 4'h0)
                     && (state == vtr_pkg::VTR_IDLE);

  function automatic logic [10:0] vec_of(input logic [3:0] g);
    logic [10:0] v;
    v = vtr_pkg::VEC_RESET;
    if (g[0]) v = vtr_pkg::VEC_EXT;
    if (g[1]) v = vtr_pkg::VEC_TIMER;
    if (g[2]) v = vtr_pkg::VEC_TBASE;
    if (g[3]) v = vtr_pkg::VEC_ADC;
    return v;
  endfunction : vec_of

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vec_done <= 1'b0;
      branch_valid <= 1'b0;
      branch_addr <= vtr_pkg::VEC_RESET;
      push_valid <= 1'b0;
      push_pc <= vtr_pkg::VEC_RESET;
      pending <= 4'h0;
    end else begin
      pending <= flags;
      push_valid <= 1'b0;
      branch_valid <= 1'b0;
      if (!reset_vec_done) begin
        reset_vec_done <= 1'b1;
        branch_valid <= 1'b1;
        branch_addr <= vtr_pkg::VEC_RESET;
      end else if (branch_go) begin
        branch_valid <= 1'b1;
        branch_addr <= vec_of(grant);
        push_valid <= 1'b1;
        push_pc <= core_pc;
      end
    end
  end

  assign held_evt = reset_vec_done && stack_full && (ready_src != 4'h0);

  a_reset_vector: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(reset_vec_done) |-> branch_valid && branch_addr == 11'h000)
    else $error("reset vector not 000h");
  a_ext_vector: assert property (@(posedge pclk) disable iff (!presetn)
    branch_go && grant == 4'h1 |=> branch_addr == 11'h004)
    else $error("external vector wrong");
  a_timer_vector: assert property (@(posedge pclk) disable iff (!presetn)
    branch_go && grant == 4'h2 |=> branch_addr == 11'h008)
    else $error("timer vector wrong");
  a_tbase_vector: assert property (@(posedge pclk) disable iff (!presetn)
    branch_go && grant == 4'h4 |=> branch_addr == 11'h00c)
    else $error("time base vector wrong");
  a_adc_vector: assert property (@(posedge pclk) disable iff (!presetn)
    branch_go && grant == 4'h8 |=> branch_addr == 11'h010)
    else $error("converter vector wrong");
  a_full_stack_hold: assert property (@(posedge pclk) disable iff (!presetn)
    stack_full && reset_vec_done |=> !push_valid && !branch_valid)
    else $error("acknowledge while stack full");
  a_push_pairs: assert property (@(posedge pclk) disable iff (!presetn)
    push_valid |-> branch_valid && push_pc == $past(core_pc))
    else $error("push without branch");
  a_priority_low: assert property (@(posedge pclk) disable iff (!presetn)
    branch_go && ready_src[0] |=> branch_addr == 11'h004)
    else $error("priority order broken");

  ////////////////////////////////////////////////////////////////
  // table read: address cycle then data cycle
  always_comb begin
    next_state = state;
    unique case (state)
      vtr_pkg::VTR_IDLE: if (tbl_req.valid) next_state = vtr_pkg::VTR_FETCH;
      vtr_pkg::VTR_FETCH: next_state = vtr_pkg::VTR_DONE;
      vtr_pkg::VTR_DONE: next_state = vtr_pkg::VTR_IDLE;
      default: next_state = vtr_pkg::VTR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= vtr_pkg::VTR_IDLE;
      req_hold <= '0;
      pmem_rd <= 1'b0;
      pmem_addr <= vtr_pkg::VEC_RESET;
      pc_shadow <= vtr_pkg::VEC_RESET;
      tbl_busy <= 1'b0;
    end else begin
      state <= next_state;
      pmem_rd <= 1'b0;
      if (state == vtr_pkg::VTR_IDLE && tbl_req.valid) begin
        req_hold <= tbl_req;
        pc_shadow <= core_pc;
        pmem_rd <= 1'b1;
        tbl_busy <= 1'b1;
        pmem_addr <= {tbl_req.last_page ? vtr_pkg::LAST_PAGE : core_pc[10:8], tbl_low};
      end else if (state == vtr_pkg::VTR_FETCH) begin
        tbl_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_wr <= '0;
      tbl_high <= vtr_pkg::TBL_HIGH_RESET;
      last_tbl_addr <= vtr_pkg::VEC_RESET;
      tbl_evt <= 1'b0;
    end else begin
      tbl_wr.valid <= 1'b0;
      tbl_evt <= 1'b0;
      if (state == vtr_pkg::VTR_FETCH) begin
        tbl_wr.valid <= 1'b1;
        tbl_wr.dest <= req_hold.dest;
        tbl_wr.low_byte <= pmem_data[7:0];
        tbl_high <= {2'h0, pmem_data[13:8]};
        last_tbl_addr <= pmem_addr;
        tbl_evt <= 1'b1;
      end
    end
  end

  a_table_two_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    state == vtr_pkg::VTR_IDLE && tbl_req.valid |=> pmem_rd ##1 tbl_wr.valid)
    else $error("table read not two cycles");
  a_last_page: assert property (@(posedge pclk) disable iff (!presetn)
    state == vtr_pkg::VTR_IDLE && tbl_req.valid && tbl_req.last_page |=> pmem_addr[10:8] == 3'h7)
    else $error("last page bits not ones");
  a_cur_page: assert property (@(posedge pclk) disable iff (!presetn)
    state == vtr_pkg::VTR_IDLE && tbl_req.valid && !tbl_req.last_page
    |=> pmem_addr[10:8] == $past(core_pc[10:8]) && pmem_addr[7:0] == $past(tbl_low))
    else $error("current page address wrong");
  a_high_fill: assert property (@(posedge pclk) disable iff (!presetn)
    tbl_wr.valid |-> tbl_high == {2'h0, $past(pmem_data[13:8])} && tbl_wr.low_byte == $past(pmem_data[7:0]))
    else $error("table data split wrong");
  a_high_ro: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr && paddr == vtr_pkg::OFF_TBL_HIGH && state != vtr_pkg::VTR_FETCH |=> $stable(tbl_high))
    else $error("high byte altered by write");

  ////////////////////////////////////////////////////////////////
  // apb registers; zero wait states, unmapped reads zero with pslverr
  logic [vtr_pkg::EV_W-1:0] stat_set;
  assign stat_set = {held_evt, tbl_evt, branch_go};
  logic [vtr_pkg::EV_W-1:0] stat_clr;
  assign stat_clr = (apb_wr && paddr == vtr_pkg::OFF_INT_CLR) ? pwdata[vtr_pkg::EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_low <= vtr_pkg::TBL_LOW_RESET;
      int_en <= '0;
    end else if (apb_wr) begin
      if (paddr == vtr_pkg::OFF_TBL_LOW) tbl_low <= pwdata[7:0];
      if (paddr == vtr_pkg::OFF_INT_EN) int_en <= pwdata[vtr_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= '0;
      irq <= 1'b0;
    end else begin
      stat <= (stat & ~stat_clr) | stat_set;
      irq <= |(((stat & ~stat_clr) | stat_set) & int_en);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd) begin
        unique case (paddr)
          vtr_pkg::OFF_TBL_LOW: prdata <= {24'h0, tbl_low};
          vtr_pkg::OFF_TBL_HIGH: prdata <= {24'h0, tbl_high};
          vtr_pkg::OFF_INT_EN: prdata <= {29'h0, int_en};
          vtr_pkg::OFF_INT_STAT: prdata <= {29'h0, stat};
          vtr_pkg::OFF_PC: prdata <= {21'h0, pc_shadow};
          vtr_pkg::OFF_LAST_TBL: prdata <= {21'h0, last_tbl_addr};
          default: begin
            prdata <= 32'h0;
            pslverr <= (paddr != vtr_pkg::OFF_INT_CLR);
          end
        endcase
      end else if (psel && !penable && pwrite) begin
        prdata <= 32'h0;
        pslverr <= !(paddr == vtr_pkg::OFF_TBL_LOW || paddr == vtr_pkg::OFF_INT_EN
                     || paddr == vtr_pkg::OFF_INT_CLR || paddr == vtr_pkg::OFF_TBL_HIGH);
      end
    end
  end
endmodule : vtr_unit

// File: include/vtr_pkg.sv
// package for the vector and table read unit
// Overview of operation
// - reset loads program counter with 000h
// - external pin either edge branches to 004h
// - timer overflow branches to 008h when allowed
// - time base event branches to 00ch
// - converter done branches to 010h
// - table pointer gives low eight address bits
// - current page uses program counter bits 10:8
// - last page forces bits 10:8 to ones
// - low word byte goes to operand register
// - upper word bits to high byte, zero filled
// - each table read takes two cycles
// - high byte register is read only
// - taken interrupt pushes program counter
// - full stack keeps flag, withholds acknowledge
package vtr_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned WORD_W = 14;
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_EXT = 11'h004;
  localparam logic [10:0] VEC_TIMER = 11'h008;
  localparam logic [10:0] VEC_TBASE = 11'h00c;
  localparam logic [10:0] VEC_ADC = 11'h010;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam logic [7:0] TBL_LOW_RESET = 8'h00;
  localparam logic [7:0] TBL_HIGH_RESET = 8'h00;
  // apb map, one word per register
  localparam logic [7:0] OFF_TBL_LOW = 8'h00;
  localparam logic [7:0] OFF_TBL_HIGH = 8'h04;
  localparam logic [7:0] OFF_INT_EN = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0c;
  localparam logic [7:0] OFF_INT_CLR = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_LAST_TBL = 8'h18;
  // event status bits
  localparam int unsigned EV_VEC = 0;
  localparam int unsigned EV_TBL = 1;
  localparam int unsigned EV_HELD = 2;
  localparam int unsigned EV_W = 3;

  typedef enum logic [1:0] {
    VTR_IDLE = 2'b00,
    VTR_FETCH = 2'b01,
    VTR_DONE = 2'b10
  } vtr_state_e;

  // one table read request from the core sequencer
  typedef struct packed {
    logic valid;
    logic last_page;
    logic [7:0] dest;
  } vtr_tbl_req_s;

  // completed table read toward data memory
  typedef struct packed {
    logic valid;
    logic [7:0] dest;
    logic [7:0] low_byte;
  } vtr_tbl_wr_s;
endpackage : vtr_pkg

// File: src/vtr_edge_sync.sv
// two flop synchroniser with both-edge detector
`timescale 1ns/100ps
module vtr_edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and result
  input wire logic pin,
  output logic edge_seen
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      edge_seen <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
      edge_seen <= sync ^ prev;
    end
  end
endmodule : vtr_edge_sync

// File: bench/vtr_pmem_model.sv
// program memory model answering table reads
`timescale 1ns/100ps
module vtr_pmem_model (
  // read port
  input wire logic pmem_rd,
  input wire logic [10:0] pmem_addr,
  output logic [13:0] pmem_data
);
  logic [13:0] w;
  assign w = {pmem_addr[10:5] ^ 6'h15, pmem_addr[7:0] ^ 8'h5a};
  // outside the read cycle the word is inverted so late sampling cannot pass
  assign pmem_data = pmem_rd ? w : ~w;
endmodule : vtr_pmem_model

// File: bench/vtr_unit_tb_top.sv
// self-checking bench for the vector and table read unit
`timescale 1ns/100ps
module vtr_unit_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, sv;
  logic ext_int_pin = 0, stack_full = 0, global_enable = 1, core_ready = 1, pready, pslverr, er;
  logic branch_valid, push_valid, tbl_busy, pmem_rd, irq;
  wire timer_ovf, tbase_evt, adc_done;
  logic [3:0] ev = 4'h0, src_enable = 4'h0, pending;
  logic [10:0] core_pc = 11'h000, branch_addr, push_pc, pmem_addr, ea;
  logic [13:0] pmem_data, w;
  vtr_pkg::vtr_tbl_req_s tbl_req = '0;
  vtr_pkg::vtr_tbl_wr_s tbl_wr;
  int fails = 0, n_checks = 0, k;
  int sx[5] = '{0, 1, 2, 3, 0};
  logic [10:0] vx[5] = '{11'h004, 11'h008, 11'h00c, 11'h010, 11'h004};
  // rows: last page, pointer, program counter
  logic [19:0] rows[6] = '{{1'b1, 8'h06, 11'h123}, {1'b1, 8'h05, 11'h000}, {1'b0, 8'h06, 11'h3a0},
    {1'b0, 8'hff, 11'h7ff}, {1'b0, 8'h00, 11'h000}, {1'b1, 8'hff, 11'h255}};
  assign {adc_done, tbase_evt, timer_ovf} = ev[3:1];
  vtr_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_int_pin, .timer_ovf, .tbase_evt, .adc_done, .src_enable, .global_enable,
    .stack_full, .core_pc, .core_ready, .branch_valid, .branch_addr, .push_valid, .push_pc,
    .pending, .tbl_req, .tbl_busy, .pmem_rd, .pmem_addr, .pmem_data, .tbl_wr, .irq);
  vtr_pmem_model pmem (.pmem_rd, .pmem_addr, .pmem_data);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // master waits for pready, no fixed latency assumed
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_br(input logic [10:0] v, input logic p);
    int i;
    @(posedge pclk) #1;
    for (i = 0; i < 20 && branch_valid !== 1'b1; i++) @(posedge pclk) #1;
    chk(branch_valid === 1'b1 && branch_addr === v && push_valid === p && (!p || push_pc === core_pc), "vector");
  endtask : wait_br
  task tbl(input logic [19:0] r);
    apb(1'b1, vtr_pkg::OFF_TBL_LOW, {24'h0, r[18:11]});
    apb(1'b0, vtr_pkg::OFF_TBL_LOW, 32'h0);
    chk(rd === {24'h0, r[18:11]}, "pointer readback");
    ea = {r[19] ? 3'h7 : r[10:8], r[18:11]};
    w = {ea[10:5] ^ 6'h15, ea[7:0] ^ 8'h5a};
    core_pc <= r[10:0];
    @(posedge pclk);
    tbl_req <= '{1'b1, r[19], ~r[18:11]};
    @(posedge pclk);
    tbl_req <= '0;
    #1 chk(pmem_rd === 1'b1 && pmem_addr === ea && tbl_busy === 1'b1, "table address");
    @(posedge pclk) #1;
    chk(tbl_wr.valid === 1'b1 && tbl_wr.low_byte === w[7:0] && tbl_wr.dest === ~r[18:11], "low byte");
    apb(1'b0, vtr_pkg::OFF_TBL_HIGH, 32'h0);
    chk(rd === {26'h0, w[13:8]}, "high byte");
  endtask : tbl
  //////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge pclk);
    chk(branch_valid === 1'b0 && pready === 1'b0 && irq === 1'b0 && tbl_wr.valid === 1'b0, "reset values");
    presetn <= 1'b1;
    wait_br(11'h000, 1'b0);
    core_pc <= 11'h2c5;
    for (k = 0; k < 6; k++) tbl(rows[k]);
    // request held through the busy cycles is taken only once
    @(posedge pclk);
    tbl_req <= '{1'b1, 1'b1, 8'h11};
    repeat (2) @(posedge pclk);
    #1 chk(tbl_wr.valid === 1'b1 && tbl_wr.dest === 8'h11 && pmem_rd === 1'b0, "busy refusal");
    @(posedge pclk);
    tbl_req <= '0;
    #1 chk(pmem_rd === 1'b0 && tbl_busy === 1'b0 && tbl_wr.valid === 1'b0, "busy refusal");
    apb(1'b0, vtr_pkg::OFF_TBL_HIGH, 32'h0);
    sv = rd;
    apb(1'b1, vtr_pkg::OFF_TBL_HIGH, 32'hff);
    apb(1'b0, vtr_pkg::OFF_TBL_HIGH, 32'h0);
    chk(rd === sv, "high byte read only");
    apb(1'b0, 8'h40, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    for (k = 0; k < 5; k++) begin
      src_enable <= 4'h1 << sx[k];
      @(posedge pclk);
      if (sx[k] == 0) ext_int_pin <= ~ext_int_pin;
      else ev <= 4'h1 << sx[k];
      @(posedge pclk);
      ev <= 4'h0;
      wait_br(vx[k], 1'b1);
    end
    src_enable <= 4'hf;
    stack_full <= 1'b1;
    @(posedge pclk);
    ev <= 4'ha;
    @(posedge pclk);
    ev <= 4'h0;
    for (k = 0; k < 6; k++) @(posedge pclk) #1 chk(branch_valid === 1'b0, "acknowledge withheld");
    chk(pending[1] === 1'b1 && pending[3] === 1'b1, "flags kept");
    @(posedge pclk);
    stack_full <= 1'b0;
    wait_br(11'h008, 1'b1);
    wait_br(11'h010, 1'b1);
    // global enable and core handshake both gate the acknowledge
    @(posedge pclk);
    global_enable <= 1'b0;
    @(posedge pclk);
    ev <= 4'h2;
    @(posedge pclk);
    ev <= 4'h0;
    repeat (4) @(posedge pclk);
    #1 chk(branch_valid === 1'b0 && pending[1] === 1'b1, "global enable off");
    @(posedge pclk);
    global_enable <= 1'b1;
    core_ready <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 chk(branch_valid === 1'b0 && push_valid === 1'b0, "core not ready");
    @(posedge pclk);
    core_ready <= 1'b1;
    wait_br(11'h008, 1'b1);
    apb(1'b1, vtr_pkg::OFF_INT_STAT, 32'h0);
    apb(1'b0, vtr_pkg::OFF_INT_STAT, 32'h0);
    chk(rd === 32'h7, "sticky status");
    apb(1'b1, vtr_pkg::OFF_INT_EN, 32'h1);
    @(posedge pclk) #1 chk(irq === 1'b1, "irq raised");
    apb(1'b1, vtr_pkg::OFF_INT_CLR, 32'h7);
    apb(1'b0, vtr_pkg::OFF_INT_STAT, 32'h0);
    chk(rd === 32'h0 && irq === 1'b0, "status cleared");
    tbl(rows[0]);
    #1 chk(irq === 1'b0, "irq masked");
    print_verdict;
  end
endmodule : vtr_unit_tb_top
